// ---- hw/cdr_regs_top.sv ----
// Configuration and status register bank of a multi-PLL clock device.
// Assumes an APB master on pclk and detector flags from logic on pclk.
//
// Operation
// - Enabled clear delay keeps loss-of-lock asserted for the programmed time.
// - Disabled clear delay releases loss-of-lock without waiting.
// - One 29-bit clear delay per channel, four bytes, low byte first.
// - Burned bank count reads 03, 0F, 3F for zero, one, two burns.
// - Writing C7 to the burn trigger starts programming the next bank.
// - Reload bit 0 copies non-volatile contents into live registers.
// - Per channel hold enable in bits 7:4 and a 29-bit hold value.
// - Ready byte reads 0F once accesses are safe, else another value.
// - Ready byte appears at the same in-page offset on every page.
// - Global gate at 0 disables all drivers, at 1 passes enables.
// - Power-down bit at 1 powers the driver off and floats its pins.
// - Enable bit 1 enables the output when set, disables when clear.
// - Half-divide bit at 1 forces divide-by-two, else programmed divider.
// - Format codes 1,2 differential, 4,5,6 single ended, others reserved.
// - Disabled level 0 low, 1 high, 2 and 3 reserved.
// - Common mode and swing apply only for formats 1 and 2.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
module cdr_regs_top #(
  parameter int BOOT_CYCLES   = cdr_pkg::BOOT_CYCLES,
  parameter int BURN_CYCLES   = cdr_pkg::BURN_CYCLES,
  parameter int RELOAD_CYCLES = cdr_pkg::RELOAD_CYCLES
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [3:0]               lock_raw,
  input  wire logic [3:0]               holdover,
  input  wire logic [7:0]               system_events,
  input  wire logic [7:0]               input_loss_events,
  output logic [3:0]                    loss_of_lock,
  output logic [3:0]                    bandwidth_hold_enable,
  output logic [3:0][28:0]              bandwidth_hold_value,
  output cdr_pkg::cdr_drv_t [7:0]       drv_cfg,
  output logic                          nv_busy,
  output logic                          irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [9:0]                idx;
  logic [7:0]                wbyte;
  logic                      wr_go;
  logic                      setup;
  cdr_pkg::cdr_state_t       state, next_state;
  logic [15:0]               busy_cnt, next_busy_cnt;
  logic [7:0]                bank, next_bank;
  logic                      burn_done, reload_done, burn_req, reload_req;
  logic                      burn_refused;
  logic [3:0]                timer_en, next_timer_en;
  logic [3:0][31:0]          dly, next_dly;
  logic [3:0]                next_bw_en;
  logic [3:0][31:0]          bw, next_bw;
  logic [7:0]                burn_reg, next_burn_reg;
  logic                      gate, next_gate;
  logic [7:0][7:0]           ctl, next_ctl;
  logic [7:0][7:0]           fmt, next_fmt;
  logic [7:0][7:0]           lvl, next_lvl;
  cdr_pkg::cdr_nv_t          nv, next_nv;
  logic [cdr_pkg::IRQ_W-1:0] irq_sts, next_irq_sts;
  logic [cdr_pkg::IRQ_W-1:0] irq_msk, next_irq_msk;
  logic [cdr_pkg::IRQ_W-1:0] irq_ev;
  logic [3:0]                lol_prev;
  logic [7:0]                tick_cnt;
  logic                      tick;
  logic [7:0]                rbyte;
  logic                      hit;
  cdr_pkg::cdr_drv_t [7:0]   next_drv;

  assign idx   = paddr[11:2];
  assign wbyte = pwdata[7:0];
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;

  // ------------------------------------------------------------
  // Delay timebase and per-channel clear timers
  // ------------------------------------------------------------

  // One tick every TICK_DIV cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 8'h00;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
      tick     <= (tick_cnt == 8'(cdr_pkg::TICK_DIV - 1));
    end
  end

  // One timer per channel
  for (genvar c = 0; c < cdr_pkg::NCH; c++) begin : g_timer
    cdr_clear_timer #(
      .W (cdr_pkg::DLY_W)
    ) u_timer (
      .pclk         (pclk),
      .presetn      (presetn),
      .tick         (tick),
      .lock_raw     (lock_raw[c]),
      .delay_en     (timer_en[c]),
      .delay        (dly[c][cdr_pkg::DLY_W-1:0]),
      .loss_of_lock (loss_of_lock[c])
    );
  end

  // ------------------------------------------------------------
  // Non-volatile sequencer
  // ------------------------------------------------------------
  assign burn_req   = wr_go & (idx == cdr_pkg::IDX_BURN)
                    & (wbyte == cdr_pkg::BURN_CODE);
  assign reload_req = wr_go & (idx == cdr_pkg::IDX_RELOAD)
                    & wbyte[cdr_pkg::RELOAD_BIT];
  assign burn_done   = (state == cdr_pkg::ST_BURN) && (busy_cnt == 16'h0);
  assign reload_done = (state == cdr_pkg::ST_RELOAD) && (busy_cnt == 16'h0);
  assign burn_refused = burn_req && (state == cdr_pkg::ST_IDLE)
                      && (bank == cdr_pkg::BANK_LAST);

  // Boot, then idle; burns and reloads run a busy count
  always_comb begin
    next_state    = state;
    next_busy_cnt = busy_cnt;
    next_bank     = bank;
    unique case (state)
      cdr_pkg::ST_BOOT, cdr_pkg::ST_BURN, cdr_pkg::ST_RELOAD: begin
        if (busy_cnt != 16'h0) begin
          next_busy_cnt = busy_cnt - 16'h1;
        end else begin
          next_state = cdr_pkg::ST_IDLE;
          if (state == cdr_pkg::ST_BURN) begin
            next_bank = {bank[5:0], 2'b11};
          end
        end
      end
      cdr_pkg::ST_IDLE: begin
        if (burn_req && bank != cdr_pkg::BANK_LAST) begin
          next_state    = cdr_pkg::ST_BURN;
          next_busy_cnt = 16'(BURN_CYCLES - 1);
        end else if (reload_req) begin
          next_state    = cdr_pkg::ST_RELOAD;
          next_busy_cnt = 16'(RELOAD_CYCLES - 1);
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= cdr_pkg::ST_BOOT;
      busy_cnt <= 16'(BOOT_CYCLES - 1);
      bank     <= cdr_pkg::BANK_NONE;
      nv_busy  <= 1'b1;
    end else begin
      state    <= next_state;
      busy_cnt <= next_busy_cnt;
      bank     <= next_bank;
      nv_busy  <= (next_state != cdr_pkg::ST_IDLE);
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------

  // Byte writes, snapshot on burn, restore on reload
  always_comb begin
    next_timer_en = timer_en;
    next_dly      = dly;
    next_bw_en    = bandwidth_hold_enable;
    next_bw       = bw;
    next_burn_reg = burn_reg;
    next_gate     = gate;
    next_ctl      = ctl;
    next_fmt      = fmt;
    next_lvl      = lvl;
    next_irq_msk  = irq_msk;
    next_nv       = nv;
    if (wr_go) begin
      if (idx == cdr_pkg::IDX_TIMER_EN) next_timer_en = wbyte[3:0];
      if (idx == cdr_pkg::IDX_BURN) next_burn_reg = wbyte;
      if (idx == cdr_pkg::IDX_BW_EN) begin
        next_bw_en = wbyte[cdr_pkg::BW_EN_LSB +: 4];
      end
      if (idx == cdr_pkg::IDX_GATE) next_gate = wbyte[cdr_pkg::GATE_BIT];
      if (idx == cdr_pkg::IDX_IRQ_MSK) begin
        next_irq_msk = wbyte[cdr_pkg::IRQ_W-1:0];
      end
      for (int c = 0; c < cdr_pkg::NCH; c++) begin
        for (int k = 0; k < 4; k++) begin
          if (idx == cdr_pkg::IDX_DLY[c] + 10'(k)) begin
            next_dly[c][k*8 +: 8] = wbyte;
          end
          if (idx == cdr_pkg::IDX_BW[c] + 10'(k)) begin
            next_bw[c][k*8 +: 8] = wbyte;
          end
        end
      end
      for (int d = 0; d < cdr_pkg::NDRV; d++) begin
        if (idx == cdr_pkg::IDX_DRV_CTL[d]) next_ctl[d] = wbyte;
        if (idx == cdr_pkg::IDX_DRV_FMT[d]) next_fmt[d] = wbyte;
        if (idx == cdr_pkg::IDX_DRV_LVL[d]) next_lvl[d] = wbyte;
      end
    end
    for (int c = 0; c < cdr_pkg::NCH; c++) begin
      next_dly[c][31:cdr_pkg::DLY_W] = '0;
      next_bw[c][31:cdr_pkg::DLY_W]  = '0;
    end
    if (burn_done) begin
      next_nv = '{ctl: ctl, fmt: fmt, lvl: lvl, gate: gate,
                  timer_en: timer_en};
    end
    if (reload_done) begin
      next_ctl      = nv.ctl;
      next_fmt      = nv.fmt;
      next_lvl      = nv.lvl;
      next_gate     = nv.gate;
      next_timer_en = nv.timer_en;
    end
  end

  // Configuration storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_en              <= 4'h0;
      dly                   <= '0;
      bandwidth_hold_enable <= 4'h0;
      bw                    <= '0;
      burn_reg              <= 8'h00;
      gate                  <= 1'b0;
      ctl                   <= {8{cdr_pkg::RST_CTL}};
      fmt                   <= {8{cdr_pkg::RST_FMT}};
      lvl                   <= {8{cdr_pkg::RST_LVL}};
      irq_msk               <= '0;
      nv                    <= '{ctl: {8{cdr_pkg::RST_CTL}},
                                 fmt: {8{cdr_pkg::RST_FMT}},
                                 lvl: {8{cdr_pkg::RST_LVL}},
                                 gate: 1'b0, timer_en: 4'h0};
    end else begin
      timer_en              <= next_timer_en;
      dly                   <= next_dly;
      bandwidth_hold_enable <= next_bw_en;
      bw                    <= next_bw;
      burn_reg              <= next_burn_reg;
      gate                  <= next_gate;
      ctl                   <= next_ctl;
      fmt                   <= next_fmt;
      lvl                   <= next_lvl;
      irq_msk               <= next_irq_msk;
      nv                    <= next_nv;
    end
  end

  // Hold values leave straight from their registers
  always_comb begin
    for (int c = 0; c < cdr_pkg::NCH; c++) begin
      bandwidth_hold_value[c] = bw[c][cdr_pkg::DLY_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Output driver settings
  // ------------------------------------------------------------

  // Effective per-driver controls
  always_comb begin
    for (int d = 0; d < cdr_pkg::NDRV; d++) begin
      next_drv[d].power_down = ctl[d][cdr_pkg::BIT_PDN];
      next_drv[d].enable     = gate
                             & ctl[d][cdr_pkg::BIT_OE]
                             & ~ctl[d][cdr_pkg::BIT_PDN];
      next_drv[d].half_div   = ctl[d][cdr_pkg::BIT_HALF];
      next_drv[d].format     = fmt[d][cdr_pkg::FMT_LSB +: 3];
      next_drv[d].disabled_level = fmt[d][cdr_pkg::DIS_LSB +: 2];
      if (fmt[d][cdr_pkg::FMT_LSB +: 3] == cdr_pkg::FMT_DIFF_NRM ||
          fmt[d][cdr_pkg::FMT_LSB +: 3] == cdr_pkg::FMT_DIFF_LP) begin
        next_drv[d].common_mode = lvl[d][cdr_pkg::CM_LSB +: 4];
        next_drv[d].swing       = lvl[d][cdr_pkg::SW_LSB +: 3];
      end else begin
        next_drv[d].common_mode = 4'h0;
        next_drv[d].swing       = 3'h0;
      end
    end
  end

  // Driver settings register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_cfg <= '0;
    end else begin
      drv_cfg <= next_drv;
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------

  // Events: new loss of lock, burn done, reload done, burn refused
  always_comb begin
    irq_ev = {burn_refused, reload_done, burn_done,
              loss_of_lock & ~lol_prev};
    next_irq_sts = irq_sts;
    if (wr_go && idx == cdr_pkg::IDX_IRQ_STS) begin
      next_irq_sts = irq_sts & ~wbyte[cdr_pkg::IRQ_W-1:0];
    end
    next_irq_sts = next_irq_sts | irq_ev;                 // Set beats clear
  end

  // Interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts  <= '0;
      lol_prev <= 4'h0;
      irq      <= 1'b0;
    end else begin
      irq_sts  <= next_irq_sts;
      lol_prev <= loss_of_lock;
      irq      <= |(next_irq_sts & irq_msk);
    end
  end

  // ------------------------------------------------------------
  // APB read decode and answer
  // ------------------------------------------------------------

  // Read byte and map hit for the current address
  always_comb begin
    rbyte = 8'h00;
    hit   = 1'b1;
    if (idx[7:0] == cdr_pkg::IDX_READY_LO) begin
      rbyte = (state == cdr_pkg::ST_IDLE) ? cdr_pkg::READY_YES
                                          : cdr_pkg::READY_NO;
    end else if (idx == cdr_pkg::IDX_TIMER_EN) begin
      rbyte = {4'h0, timer_en};
    end else if (idx == cdr_pkg::IDX_BANK) begin
      rbyte = bank;
    end else if (idx == cdr_pkg::IDX_BURN) begin
      rbyte = burn_reg;
    end else if (idx == cdr_pkg::IDX_RELOAD) begin
      rbyte = 8'h00;
    end else if (idx == cdr_pkg::IDX_BW_EN) begin
      rbyte = {bandwidth_hold_enable, 4'h0};
    end else if (idx == cdr_pkg::IDX_FSUM) begin
      rbyte = {5'h00, |{holdover, loss_of_lock}, |input_loss_events,
               |system_events};
    end else if (idx == cdr_pkg::IDX_FSYS) begin
      rbyte = system_events;
    end else if (idx == cdr_pkg::IDX_FLOSS) begin
      rbyte = input_loss_events;
    end else if (idx == cdr_pkg::IDX_FLOCK) begin
      rbyte = {holdover, loss_of_lock};
    end else if (idx == cdr_pkg::IDX_GATE) begin
      rbyte = {7'h00, gate};
    end else if (idx == cdr_pkg::IDX_IRQ_STS) begin
      rbyte = {1'b0, irq_sts};
    end else if (idx == cdr_pkg::IDX_IRQ_MSK) begin
      rbyte = {1'b0, irq_msk};
    end else begin
      hit = 1'b0;
    end
    for (int c = 0; c < cdr_pkg::NCH; c++) begin
      for (int k = 0; k < 4; k++) begin
        if (idx == cdr_pkg::IDX_DLY[c] + 10'(k)) begin
          rbyte = dly[c][k*8 +: 8];
          hit   = 1'b1;
        end
        if (idx == cdr_pkg::IDX_BW[c] + 10'(k)) begin
          rbyte = bw[c][k*8 +: 8];
          hit   = 1'b1;
        end
      end
    end
    for (int d = 0; d < cdr_pkg::NDRV; d++) begin
      if (idx == cdr_pkg::IDX_DRV_CTL[d]) begin
        rbyte = ctl[d];
        hit   = 1'b1;
      end
      if (idx == cdr_pkg::IDX_DRV_FMT[d]) begin
        rbyte = fmt[d];
        hit   = 1'b1;
      end
      if (idx == cdr_pkg::IDX_DRV_LVL[d]) begin
        rbyte = lvl[d];
        hit   = 1'b1;
      end
    end
  end

  // Answer in the first access cycle, captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup && !pwrite && hit) ? {24'h00_0000, rbyte}
                                           : 32'h0000_0000;
    end
  end

endmodule // cdr_regs_top

// ---- hw/cdr_pkg.sv ----
// Shared constants and types for the clock device register bank.
// Assumes one 20 MHz clock and a flat APB byte-per-word register map.
package cdr_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int IDX_W = 10;
  localparam int NCH   = 4;
  localparam int NDRV  = 8;
  localparam int DLY_W = 29;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [9:0]       IDX_TIMER_EN = 10'h0a2;
  localparam logic [3:0][9:0]  IDX_DLY = {10'h0b3, 10'h0ae, 10'h0a9, 10'h0a4};
  localparam logic [9:0]       IDX_BANK     = 10'h0e2;
  localparam logic [9:0]       IDX_BURN     = 10'h0e3;
  localparam logic [9:0]       IDX_RELOAD   = 10'h0e4;
  localparam logic [9:0]       IDX_BW_EN    = 10'h0e5;
  localparam logic [3:0][9:0]  IDX_BW  = {10'h0f2, 10'h0ee, 10'h0ea, 10'h0e6};
  localparam logic [9:0]       IDX_FSUM     = 10'h0f6;
  localparam logic [9:0]       IDX_FSYS     = 10'h0f7;
  localparam logic [9:0]       IDX_FLOSS    = 10'h0f8;
  localparam logic [9:0]       IDX_FLOCK    = 10'h0f9;
  localparam logic [7:0]       IDX_READY_LO = 8'hfe;
  localparam logic [9:0]       IDX_GATE     = 10'h102;
  localparam logic [7:0][9:0]  IDX_DRV_CTL = {10'h13a, 10'h130, 10'h12b,
    10'h126, 10'h11c, 10'h117, 10'h112, 10'h108};
  localparam logic [7:0][9:0]  IDX_DRV_FMT = {10'h13b, 10'h131, 10'h12c,
    10'h127, 10'h11d, 10'h118, 10'h113, 10'h109};
  localparam logic [7:0][9:0]  IDX_DRV_LVL = {10'h137, 10'h132, 10'h12d,
    10'h128, 10'h11e, 10'h119, 10'h114, 10'h10a};
  localparam logic [9:0]       IDX_IRQ_STS  = 10'h180;
  localparam logic [9:0]       IDX_IRQ_MSK  = 10'h181;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_PDN    = 0;
  localparam int BIT_OE     = 1;
  localparam int BIT_HALF   = 2;
  localparam int FMT_LSB    = 0;
  localparam int DIS_LSB    = 4;
  localparam int CM_LSB     = 0;
  localparam int SW_LSB     = 4;
  localparam int BW_EN_LSB  = 4;
  localparam int RELOAD_BIT = 0;
  localparam int GATE_BIT   = 0;
  localparam int IRQ_BURN   = 4;
  localparam int IRQ_RELOAD = 5;
  localparam int IRQ_REFUSE = 6;
  localparam int IRQ_W      = 7;

  // ------------------------------------------------------------
  // Codes and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] BURN_CODE    = 8'hc7;
  localparam logic [7:0] BANK_NONE    = 8'h03;
  localparam logic [7:0] BANK_LAST    = 8'h3f;
  localparam logic [7:0] READY_YES    = 8'h0f;
  localparam logic [7:0] READY_NO     = 8'h00;
  localparam logic [2:0] FMT_DIFF_NRM = 3'h1;
  localparam logic [2:0] FMT_DIFF_LP  = 3'h2;
  localparam logic [7:0] RST_CTL      = 8'h00;
  localparam logic [7:0] RST_FMT      = 8'h01;
  localparam logic [7:0] RST_LVL      = 8'h00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 20;
  localparam int BOOT_TIME_US   = 50;
  localparam int BURN_TIME_US   = 100;
  localparam int RELOAD_TIME_US = 10;
  localparam int BOOT_CYCLES    = BOOT_TIME_US * CLK_MHZ;
  localparam int BURN_CYCLES    = BURN_TIME_US * CLK_MHZ;
  localparam int RELOAD_CYCLES  = RELOAD_TIME_US * CLK_MHZ;
  localparam int TICK_DIV       = 256;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_BURN, ST_RELOAD}
    cdr_state_t;

  typedef struct packed {
    logic       power_down;
    logic       enable;
    logic       half_div;
    logic [2:0] format;
    logic [1:0] disabled_level;
    logic [3:0] common_mode;
    logic [2:0] swing;
  } cdr_drv_t;

  typedef struct packed {
    logic [7:0][7:0] ctl;
    logic [7:0][7:0] fmt;
    logic [7:0][7:0] lvl;
    logic            gate;
    logic [3:0]      timer_en;
  } cdr_nv_t;

endpackage

// ---- hw/cdr_clear_timer.sv ----
// Loss-of-lock clear delay for one PLL channel.
// Assumes lock_raw and tick come from logic on pclk; tick is one cycle wide.
`timescale 1ns/10ps
module cdr_clear_timer #(
  parameter int W = 29
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic         lock_raw,
  input  wire logic         delay_en,
  input  wire logic [W-1:0] delay,
  output logic              loss_of_lock
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_loss_of_lock;

  // Hold the indication, then release at once or after the delay
  always_comb begin
    next_loss_of_lock = loss_of_lock;
    next_count        = count;
    if (lock_raw) begin
      next_loss_of_lock = 1'b1;
      next_count        = '0;
    end else if (loss_of_lock) begin
      if (!delay_en) begin
        next_loss_of_lock = 1'b0;
      end else if (count >= delay) begin
        next_loss_of_lock = 1'b0;
      end else if (tick) begin
        next_count = count + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_of_lock <= 1'b0;
      count        <= '0;
    end else begin
      loss_of_lock <= next_loss_of_lock;
      count        <= next_count;
    end
  end

endmodule // cdr_clear_timer

// ---- tb/cdr_regs_assertions.sv ----
// Port checks for the register bank.
// Assumes one pclk domain, presetn async active low.
`timescale 1ns/10ps
module cdr_regs_assertions (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [31:0]             prdata,
  input wire logic [3:0]              lock_raw,
  input wire logic [3:0]              loss_of_lock,
  input wire logic                    irq,
  input wire cdr_pkg::cdr_drv_t [7:0] drv_cfg
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus handshake
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_data_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_data_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Loss of lock and driver settings
  a_lock_sets: assert property (lock_raw[0] |=> loss_of_lock[0])
    else $error("loss of lock not raised");
  a_pdn_disables: assert property
    (drv_cfg[0].power_down |-> !drv_cfg[0].enable)
    else $error("powered down driver enabled");
  a_level_gated: assert property
    (!(drv_cfg[0].format inside {3'h1, 3'h2}) |->
     {drv_cfg[0].common_mode, drv_cfg[0].swing} == 7'h00)
    else $error("level fields leak");
  cover property (pslverr);
  cover property (irq);
  cover property ($fell(loss_of_lock[0]));
endmodule  // cdr_regs_assertions

// ---- tb/cdr_host_model.sv ----
// Host on the register bus, one APB transfer at a time.
// Assumes pclk from the bench; tb holds the closing task.
`timescale 1ns/10ps
module cdr_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Request held until pready is sampled high
  task automatic xfer(input logic w, input logic [9:0] i,
                      input logic [7:0] d, output logic [8:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, i, 26'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    r = {pslverr, prdata[7:0]};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      tb.n_mismatch++;
      tb.test_done();
    end
  endtask
endmodule  // cdr_host_model

// ---- tb/tb.sv ----
// Bench: ready test, then table of register accesses, driver,
// loss-of-lock, error and interrupt tests. Needs cdr_host_model.
`timescale 1ns/10ps
module tb;
  logic                    pclk, presetn, psel, penable, pwrite, pready;
  logic                    pslverr, nv_busy, irq;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata;
  logic [3:0]              lock_raw, loss_of_lock, holdover;
  logic [3:0]              bandwidth_hold_enable;
  logic [7:0]              system_events;
  cdr_pkg::cdr_drv_t [7:0] drv_cfg;
  logic [8:0]              r;
  int                      n_mismatch, comparisons;
  // Rows: op (1 write, 2 read and compare, 3 wait idle), index, data
  logic [19:0] rows [26] = '{20'h8e203, 20'h4e200, 20'h8e203,
    20'h4a7ff, 20'h8a71f, 20'h4e5f0, 20'h8e5f0, 20'h58110,
    20'h4e3c7, 20'hc0000, 20'h8e20f, 20'h98010, 20'h58010,
    20'h4e3c7, 20'hc0000, 20'h8e23f, 20'h4e3c7, 20'hc0000,
    20'h8e23f, 20'h98050, 20'h50806, 20'h90806, 20'h4e401,
    20'hc0000, 20'h90800, 20'h8e400};
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  cdr_host_model host (.pclk, .pready, .pslverr, .prdata, .psel,
    .penable, .pwrite, .paddr, .pwdata);
  cdr_regs_top #(.BOOT_CYCLES(8), .BURN_CYCLES(8), .RELOAD_CYCLES(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .lock_raw,
    .holdover, .system_events, .input_loss_events(8'h00),
    .loss_of_lock, .bandwidth_hold_enable, .bandwidth_hold_value(),
    .drv_cfg, .nv_busy, .irq);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Write, let the settings register, compare driver 0
  task automatic wchk(input logic [9:0] i, input logic [7:0] d,
                      input logic [14:0] e);
    host.xfer(1'b1, i, d, r);
    repeat (2) @(posedge pclk);
    chk(drv_cfg[0], e);
  endtask
  task automatic test_done;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    {presetn, lock_raw, holdover, system_events} = '0;
    {n_mismatch, comparisons} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    host.xfer(1'b0, 10'h0fe, 8'h00, r);
    chk(r, {1'b0, cdr_pkg::READY_NO});
    for (int n = 0; n < 40 && r[7:0] !== cdr_pkg::READY_YES; n++)
      host.xfer(1'b0, 10'h0fe, 8'h00, r);
    host.xfer(1'b0, 10'h2fe, 8'h00, r);
    chk(r, {1'b0, cdr_pkg::READY_YES});
    foreach (rows[k]) begin
      if (rows[k][19:18] == 2'd3) begin
        repeat (2) @(posedge pclk);
        for (int n = 0; n < 99 && nv_busy !== 1'b0; n++)
          @(posedge pclk);
        chk(nv_busy, 32'h0);
      end else begin
        host.xfer(rows[k][18], rows[k][17:8], rows[k][7:0], r);
        if (rows[k][19])
          chk(r, {24'h0, rows[k][7:0]});
      end
    end
    chk(bandwidth_hold_enable, 32'hf);
    // Reload restored control 0 to its default: set enable and half again
    host.xfer(1'b1, 10'h108, 8'h06, r);
    host.xfer(1'b1, 10'h109, 8'h11, r);
    wchk(10'h10a, 8'h35, 15'h12ab);
    wchk(10'h102, 8'h01, 15'h32ab);
    wchk(10'h108, 8'h07, 15'h52ab);
    wchk(10'h109, 8'h14, 15'h5880);
    lock_raw <= 4'h1;
    repeat (2) @(posedge pclk);
    lock_raw <= 4'h0;
    repeat (2) @(posedge pclk);
    chk(loss_of_lock, 32'h0);
    // Flag bytes read back as driven, summary ORs them
    {holdover, system_events} <= 12'h221;
    host.xfer(1'b0, 10'h0f9, 8'h00, r);
    chk(r, 32'h20);
    host.xfer(1'b0, 10'h0f7, 8'h00, r);
    chk(r, 32'h21);
    host.xfer(1'b0, 10'h0f6, 8'h00, r);
    chk(r, 32'h05);
    host.xfer(1'b1, 10'h0a2, 8'h01, r);
    lock_raw <= 4'h1;
    repeat (2) @(posedge pclk);
    lock_raw <= 4'h0;
    repeat (300) @(posedge pclk);
    chk(loss_of_lock, 32'h1);
    host.xfer(1'b0, 10'h3ff, 8'h00, r);
    chk(r, 32'h100);
    chk(irq, 32'h1);
    host.xfer(1'b1, 10'h180, 8'hff, r);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    test_done();
  end
endmodule  // tb
bind cdr_regs_top cdr_regs_assertions u_chk (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .prdata, .lock_raw, .loss_of_lock, .irq,
  .drv_cfg);
